// File: design/cfr_consts.vh
`ifndef CFR_CONSTS_VH
`define CFR_CONSTS_VH

// ********************************
// Word widths
// ********************************
`define CFR_INSN_W 12
`define CFR_DATA_W 8
`define CFR_FADDR_W 7
`define CFR_FULL_PC_W 11

// ********************************
// Special register offsets
// ********************************
`define CFR_ADDR_INDIRECT 5'h00
`define CFR_ADDR_TIMER 5'h01
`define CFR_ADDR_PCL 5'h02
`define CFR_ADDR_STATUS 5'h03
`define CFR_ADDR_POINTER 5'h04
`define CFR_ADDR_IO_A 5'h05
`define CFR_ADDR_IO_B 5'h06
`define CFR_ADDR_IO_C 5'h07
`define CFR_SFR_LIMIT 5'h08
`define CFR_BANK_BIT 4

// ********************************
// Flag register fields
// ********************************
`define CFR_ST_C 0
`define CFR_ST_DC 1
`define CFR_ST_Z 2
`define CFR_ST_PD 3
`define CFR_ST_TO 4
`define CFR_ST_PA_LO 5
`define CFR_ST_PA_HI 6

// ********************************
// Reset values
// ********************************
`define CFR_STATUS_POR 8'h18
`define CFR_DIR_RESET 8'hff
`define CFR_OPTION_RESET 6'h3f
`define CFR_DATA_POR 8'h00
`define CFR_DIR_RESET_A 4'hf
`define CFR_NIB_POR 4'h0

// ********************************
// Arithmetic unit operations
// ********************************
`define CFR_ALU_PASS_A 4'h0
`define CFR_ALU_CLR 4'h1
`define CFR_ALU_SUB 4'h2
`define CFR_ALU_DEC 4'h3
`define CFR_ALU_IOR 4'h4
`define CFR_ALU_AND 4'h5
`define CFR_ALU_XOR 4'h6
`define CFR_ALU_ADD 4'h7
`define CFR_ALU_MOVF 4'h8
`define CFR_ALU_COM 4'h9
`define CFR_ALU_INC 4'ha
`define CFR_ALU_DECSZ 4'hb
`define CFR_ALU_RRF 4'hc
`define CFR_ALU_RLF 4'hd
`define CFR_ALU_SWAP 4'he
`define CFR_ALU_INCSZ 4'hf

// ********************************
// Instruction encodings
// ********************************
`define CFR_I_NOP 12'h000
`define CFR_I_OPTION 12'h002
`define CFR_I_SLEEP 12'h003
`define CFR_I_CLRWDT 12'h004
`define CFR_I_CLRW 12'h040
`define CFR_I_PIN_DIRECTION_CONTROL_HI 9'h000
`define CFR_I_MOVWF_HI 7'h01
`define CFR_I_CLRF_HI 7'h03
`define CFR_G_MISC 4'h0
`define CFR_G_BCF 4'h4
`define CFR_G_BSF 4'h5
`define CFR_G_BTFSC 4'h6
`define CFR_G_BTFSS 4'h7
`define CFR_G_RETLW 4'h8
`define CFR_G_CALL 4'h9
`define CFR_G_GOTO_A 4'ha
`define CFR_G_GOTO_B 4'hb
`define CFR_G_MOVLW 4'hc
`define CFR_G_IORLW 4'hd
`define CFR_G_ANDLW 4'he
`define CFR_G_XORLW 4'hf

`endif

// File: design/cfr_alu.v
`timescale 1ns/1ns
`include "cfr_consts.vh"

// ********************************
// Eight-bit arithmetic unit
// ********************************
module cfr_alu (
    // Operation and operands
    input wire [3:0] op,
    input wire [7:0] a,
    input wire [7:0] b,
    input wire cin,
    // Result and flags
    output reg [7:0] y,
    output reg c,
    output reg dc,
    output reg c_upd,
    output reg dc_upd
);
    wire [8:0] sum = {1'b0, a} + {1'b0, b};
    wire [4:0] nsum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    // Subtract is b minus a, carry high means no borrow
    wire [8:0] dif = {1'b0, b} + {1'b0, ~a} + 9'h001;
    wire [4:0] ndif = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;

    always @* begin
        y = a;
        c = 1'b0;
        dc = 1'b0;
        c_upd = 1'b0;
        dc_upd = 1'b0;
        case (op)
            `CFR_ALU_PASS_A: y = a;
            `CFR_ALU_CLR: y = 8'h00;
            `CFR_ALU_SUB: begin
                y = dif[7:0];
                c = dif[8];
                dc = ndif[4];
                c_upd = 1'b1;
                dc_upd = 1'b1;
            end
            `CFR_ALU_DEC, `CFR_ALU_DECSZ: y = b - 8'h01;
            `CFR_ALU_IOR: y = a | b;
            `CFR_ALU_AND: y = a & b;
            `CFR_ALU_XOR: y = a ^ b;
            `CFR_ALU_ADD: begin
                y = sum[7:0];
                c = sum[8];
                dc = nsum[4];
                c_upd = 1'b1;
                dc_upd = 1'b1;
            end
            `CFR_ALU_MOVF: y = b;
            `CFR_ALU_COM: y = ~b;
            `CFR_ALU_INC, `CFR_ALU_INCSZ: y = b + 8'h01;
            `CFR_ALU_RRF: begin
                y = {cin, b[7:1]};
                c = b[0];
                c_upd = 1'b1;
            end
            `CFR_ALU_RLF: begin
                y = {b[6:0], cin};
                c = b[7];
                c_upd = 1'b1;
            end
            `CFR_ALU_SWAP: y = {b[3:0], b[7:4]};
            default: y = a;
        endcase
    end
endmodule

// File: design/cfr_stack.v
`timescale 1ns/1ns

// ********************************
// Two-level return stack
// ********************************
module cfr_stack #(
    parameter WIDTH = 11
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Push and pop
    input wire push,
    input wire pop,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] top
);
    reg [WIDTH-1:0] lvl [0:1];

    assign top = lvl[0];

    // Overflow drops the oldest entry; underflow repeats the deepest one
    always @(posedge clk) begin
        if (!rst_b) begin
            lvl[0] <= {WIDTH{1'b0}};
            lvl[1] <= {WIDTH{1'b0}};
        end else if (push) begin
            lvl[1] <= lvl[0];
            lvl[0] <= din;
        end else if (pop) begin
            lvl[0] <= lvl[1];
        end
    end
endmodule

// File: design/cfr_core.v
`timescale 1ns/1ns
`include "cfr_consts.vh"

module cfr_core #(
    parameter PC_WIDTH = 11,
    parameter BANKED = 1,
    parameter HAS_PORT_C = 1
) (
    // Clock and power-on reset
    input wire CLK,
    input wire RST_B,
    // Warm reset sources
    input wire EXTERNAL_CLEAR_INPUT_B,
    input wire WATCHDOG_RESET,
    // Program bus
    output wire [PC_WIDTH-1:0] PROG_ADDR,
    input wire [11:0] PROG_DATA,
    // Data register file
    output reg [6:0] DATA_ADDR,
    input wire [7:0] DATA_RDATA,
    output reg [6:0] DATA_WADDR,
    output reg [7:0] DATA_WDATA,
    output reg DATA_WE,
    // Port latches and directions
    output reg [3:0] IO_BANK_A_LATCH,
    output reg [7:0] IO_BANK_B_LATCH,
    output reg [7:0] IO_BANK_C_LATCH,
    output reg [3:0] PIN_DIRECTION_A,
    output reg [7:0] PIN_DIRECTION_B,
    output reg [7:0] PIN_DIRECTION_C,
    // Core state
    output reg [7:0] WORKING_ACCUMULATOR,
    output reg [7:0] STATUS_FLAGS,
    output reg [7:0] TIMER_COUNT_VALUE,
    output reg [5:0] PRESCALER_TIMER_CONFIG,
    output reg WATCHDOG_CLEAR,
    output reg SLEEP_REQUEST
);
    // ********************************
    // State
    // ********************************
    reg [PC_WIDTH-1:0] program_counter;
    reg [11:0] ir;
    reg [7:0] indirect_pointer;
    reg clr_meta;
    reg clr_sync;

    wire [7:0] w = WORKING_ACCUMULATOR;
    wire [7:0] status = STATUS_FLAGS;
    wire [1:0] page = status[`CFR_ST_PA_HI:`CFR_ST_PA_LO];
    wire warm = !clr_sync || WATCHDOG_RESET;

    assign PROG_ADDR = program_counter;

    // ********************************
    // Helpers
    // ********************************
    // Pointer as software sees it: unused upper bits read as ones
    function [7:0] ptr_view;
        input [7:0] p;
        begin
            if (BANKED != 0)
                ptr_view = {1'b1, p[6:0]};
            else
                ptr_view = {3'h7, p[4:0]};
        end
    endfunction

    // File address of an instruction, indirect through address zero
    function [6:0] eff_addr;
        input [11:0] ins;
        input [7:0] p;
        begin
            if (ins[4:0] == `CFR_ADDR_INDIRECT)
                eff_addr = (BANKED != 0) ? p[6:0] : {2'h0, p[4:0]};
            else if (BANKED != 0 && ins[`CFR_BANK_BIT])
                eff_addr = {p[6:5], ins[4:0]};
            else
                eff_addr = {2'h0, ins[4:0]};
        end
    endfunction

    function is_sfr;
        input [6:0] a;
        begin
            is_sfr = (a[4:0] < `CFR_SFR_LIMIT) &&
                !(HAS_PORT_C == 0 && a[4:0] == `CFR_ADDR_IO_C);
        end
    endfunction

    // ********************************
    // Arithmetic unit and stack
    // ********************************
    reg [3:0] alu_op;
    reg [7:0] alu_a;
    reg [7:0] rd_f;
    wire [7:0] res;
    wire alu_c;
    wire alu_dc;
    wire c_upd;
    wire dc_upd;
    reg push;
    reg pop;
    wire [PC_WIDTH-1:0] stack_top;

    cfr_alu u_alu (
        .op(alu_op),
        .a(alu_a),
        .b(rd_f),
        .cin(status[`CFR_ST_C]),
        .y(res),
        .c(alu_c),
        .dc(alu_dc),
        .c_upd(c_upd),
        .dc_upd(dc_upd)
    );

    cfr_stack #(.WIDTH(PC_WIDTH)) u_stack (
        .clk(CLK),
        .rst_b(RST_B),
        .push(push),
        .pop(pop),
        .din(program_counter),
        .top(stack_top)
    );

    // ********************************
    // Decode and execute
    // ********************************
    reg [7:0] mask;
    reg z_en;
    reg to_w;
    reg to_f;
    reg skip;
    reg skip_zero;
    reg do_goto;
    reg do_call;
    reg do_option;
    reg do_pin_direction_control;
    reg do_sleep;
    reg do_clrwdt;
    reg [10:0] tgt;
    reg [PC_WIDTH-1:0] next_pc;
    reg [11:0] next_ir;
    reg [7:0] next_w;
    reg [7:0] next_status;
    reg [7:0] next_ptr;
    reg [7:0] next_tmr;
    reg [3:0] next_lat_a;
    reg [7:0] next_lat_b;
    reg [7:0] next_lat_c;
    reg [3:0] next_dir_a;
    reg [7:0] next_dir_b;
    reg [7:0] next_dir_c;
    reg [5:0] next_opt;
    reg next_we;

    always @* begin
        // Pending write to the same file is forwarded, the file has not taken it yet
        if (is_sfr(DATA_ADDR)) begin
            case (DATA_ADDR[4:0])
                `CFR_ADDR_TIMER: rd_f = TIMER_COUNT_VALUE;
                `CFR_ADDR_PCL: rd_f = program_counter[7:0];
                `CFR_ADDR_STATUS: rd_f = status;
                `CFR_ADDR_POINTER: rd_f = ptr_view(indirect_pointer);
                `CFR_ADDR_IO_A: rd_f = {4'h0, IO_BANK_A_LATCH};
                `CFR_ADDR_IO_B: rd_f = IO_BANK_B_LATCH;
                `CFR_ADDR_IO_C: rd_f = IO_BANK_C_LATCH;
                default: rd_f = 8'h00;
            endcase
        end else if (DATA_WE && DATA_WADDR == DATA_ADDR) begin
            rd_f = DATA_WDATA;
        end else begin
            rd_f = DATA_RDATA;
        end
    end

    always @* begin
        mask = 8'h01 << ir[7:5];
        alu_op = `CFR_ALU_PASS_A;
        alu_a = w;
        z_en = 1'b0;
        to_w = 1'b0;
        to_f = 1'b0;
        skip = 1'b0;
        skip_zero = 1'b0;
        do_goto = 1'b0;
        do_call = 1'b0;
        pop = 1'b0;
        do_option = 1'b0;
        do_pin_direction_control = 1'b0;
        do_sleep = 1'b0;
        do_clrwdt = 1'b0;
        if (ir[11:10] == 2'h0 && ir[9:6] >= `CFR_ALU_SUB) begin
            alu_op = ir[9:6];
            to_w = !ir[5];
            to_f = ir[5];
            skip_zero = (ir[9:6] == `CFR_ALU_DECSZ) || (ir[9:6] == `CFR_ALU_INCSZ);
            z_en = !skip_zero && ir[9:6] != `CFR_ALU_RRF &&
                ir[9:6] != `CFR_ALU_RLF && ir[9:6] != `CFR_ALU_SWAP;
        end else begin
            case (ir[11:8])
                `CFR_G_MISC: begin
                    if (ir == `CFR_I_OPTION) begin
                        do_option = 1'b1;
                    end else if (ir == `CFR_I_SLEEP) begin
                        do_sleep = 1'b1;
                    end else if (ir == `CFR_I_CLRWDT) begin
                        do_clrwdt = 1'b1;
                    end else if (ir[11:3] == `CFR_I_PIN_DIRECTION_CONTROL_HI) begin
                        do_pin_direction_control = 1'b1;
                    end else if (ir[11:5] == `CFR_I_MOVWF_HI) begin
                        to_f = 1'b1;
                    end else if (ir == `CFR_I_CLRW || ir[11:5] == `CFR_I_CLRF_HI) begin
                        alu_op = `CFR_ALU_CLR;
                        to_w = (ir == `CFR_I_CLRW);
                        to_f = (ir != `CFR_I_CLRW);
                        z_en = 1'b1;
                    end
                end
                `CFR_G_BCF: begin
                    alu_a = ~mask;
                    alu_op = `CFR_ALU_AND;
                    to_f = 1'b1;
                end
                `CFR_G_BSF: begin
                    alu_a = mask;
                    alu_op = `CFR_ALU_IOR;
                    to_f = 1'b1;
                end
                `CFR_G_BTFSC: skip = (rd_f & mask) == 8'h00;
                `CFR_G_BTFSS: skip = (rd_f & mask) != 8'h00;
                `CFR_G_RETLW: begin
                    alu_a = ir[7:0];
                    to_w = 1'b1;
                    pop = 1'b1;
                end
                `CFR_G_CALL: do_call = 1'b1;
                `CFR_G_GOTO_A, `CFR_G_GOTO_B: do_goto = 1'b1;
                `CFR_G_MOVLW: begin
                    alu_a = ir[7:0];
                    to_w = 1'b1;
                end
                default: begin
                    alu_a = ir[7:0];
                    alu_op = (ir[11:8] == `CFR_G_IORLW) ? `CFR_ALU_IOR :
                        (ir[11:8] == `CFR_G_ANDLW) ? `CFR_ALU_AND : `CFR_ALU_XOR;
                    to_w = 1'b1;
                    z_en = 1'b1;
                end
            endcase
        end
        if (skip_zero)
            skip = (res == 8'h00);
        push = do_call;

        // Register writes
        next_w = to_w ? res : w;
        next_status = status;
        next_ptr = indirect_pointer;
        next_tmr = TIMER_COUNT_VALUE;
        next_lat_a = IO_BANK_A_LATCH;
        next_lat_b = IO_BANK_B_LATCH;
        next_lat_c = IO_BANK_C_LATCH;
        next_we = 1'b0;
        if (to_f && is_sfr(DATA_ADDR)) begin
            case (DATA_ADDR[4:0])
                `CFR_ADDR_TIMER: next_tmr = res;
                // Power-down and time-out bits are not writable
                `CFR_ADDR_STATUS: next_status = {res[7:`CFR_ST_PA_LO],
                    status[`CFR_ST_TO:`CFR_ST_PD], res[`CFR_ST_Z:`CFR_ST_C]};
                `CFR_ADDR_POINTER: next_ptr = res;
                `CFR_ADDR_IO_A: next_lat_a = res[3:0];
                `CFR_ADDR_IO_B: next_lat_b = res;
                `CFR_ADDR_IO_C: next_lat_c = res;
                default: next_we = 1'b0;
            endcase
        end else if (to_f) begin
            next_we = 1'b1;
        end
        if (c_upd)
            next_status[`CFR_ST_C] = alu_c;
        if (dc_upd)
            next_status[`CFR_ST_DC] = alu_dc;
        if (z_en)
            next_status[`CFR_ST_Z] = (res == 8'h00);
        if (do_sleep) begin
            next_status[`CFR_ST_PD] = 1'b0;
            next_status[`CFR_ST_TO] = 1'b1;
        end
        if (do_clrwdt) begin
            next_status[`CFR_ST_PD] = 1'b1;
            next_status[`CFR_ST_TO] = 1'b1;
        end

        next_opt = do_option ? w[5:0] : PRESCALER_TIMER_CONFIG;
        next_dir_a = PIN_DIRECTION_A;
        next_dir_b = PIN_DIRECTION_B;
        next_dir_c = PIN_DIRECTION_C;
        if (do_pin_direction_control) begin
            if (ir[4:0] == `CFR_ADDR_IO_A)
                next_dir_a = w[3:0];
            if (ir[4:0] == `CFR_ADDR_IO_B)
                next_dir_b = w;
            if (ir[4:0] == `CFR_ADDR_IO_C && HAS_PORT_C != 0)
                next_dir_c = w;
        end

        // Program flow: page bits form the upper counter bits
        if (do_goto)
            tgt = {page, ir[8:0]};
        else if (do_call)
            tgt = {page, 1'b0, ir[7:0]};
        else
            tgt = {page, 1'b0, res};
        if (pop) begin
            next_pc = stack_top;
            next_ir = `CFR_I_NOP;
        end else if (do_goto || do_call ||
                (to_f && is_sfr(DATA_ADDR) && DATA_ADDR[4:0] == `CFR_ADDR_PCL)) begin
            // Upper bits beyond the implemented counter are dropped
            next_pc = tgt[PC_WIDTH-1:0];
            next_ir = `CFR_I_NOP;
        end else if (skip) begin
            next_pc = program_counter + {{(PC_WIDTH-1){1'b0}}, 1'b1};
            next_ir = `CFR_I_NOP;
        end else begin
            // Counter rolls over from the last word to zero
            next_pc = program_counter + {{(PC_WIDTH-1){1'b0}}, 1'b1};
            next_ir = PROG_DATA;
        end
    end

    // ********************************
    // Registers
    // ********************************
    // External clear is a pin, so it is synchronised first
    always @(posedge CLK) begin
        if (!RST_B) begin
            clr_meta <= 1'b1;
            clr_sync <= 1'b1;
        end else begin
            clr_meta <= EXTERNAL_CLEAR_INPUT_B;
            clr_sync <= clr_meta;
        end
    end

    always @(posedge CLK) begin
        if (!RST_B) begin
            program_counter <= {PC_WIDTH{1'b1}};
            ir <= `CFR_I_NOP;
            STATUS_FLAGS <= `CFR_STATUS_POR;
            PRESCALER_TIMER_CONFIG <= `CFR_OPTION_RESET;
            PIN_DIRECTION_A <= `CFR_DIR_RESET_A;
            PIN_DIRECTION_B <= `CFR_DIR_RESET;
            PIN_DIRECTION_C <= `CFR_DIR_RESET;
            // Undefined at power-on; zero keeps simulation clean
            WORKING_ACCUMULATOR <= `CFR_DATA_POR;
            indirect_pointer <= `CFR_DATA_POR;
            TIMER_COUNT_VALUE <= `CFR_DATA_POR;
            IO_BANK_A_LATCH <= `CFR_NIB_POR;
            IO_BANK_B_LATCH <= `CFR_DATA_POR;
            IO_BANK_C_LATCH <= `CFR_DATA_POR;
            DATA_ADDR <= 7'h00;
            DATA_WADDR <= 7'h00;
            DATA_WDATA <= 8'h00;
            DATA_WE <= 1'b0;
            WATCHDOG_CLEAR <= 1'b0;
            SLEEP_REQUEST <= 1'b0;
        end else if (warm) begin
            // Data registers and the accumulator are left alone
            program_counter <= {PC_WIDTH{1'b1}};
            ir <= `CFR_I_NOP;
            STATUS_FLAGS <= {3'h0,
                WATCHDOG_RESET ? 1'b0 : status[`CFR_ST_TO],
                status[`CFR_ST_PD], status[`CFR_ST_Z:`CFR_ST_C]};
            PRESCALER_TIMER_CONFIG <= `CFR_OPTION_RESET;
            PIN_DIRECTION_A <= `CFR_DIR_RESET_A;
            PIN_DIRECTION_B <= `CFR_DIR_RESET;
            PIN_DIRECTION_C <= `CFR_DIR_RESET;
            DATA_WE <= 1'b0;
            WATCHDOG_CLEAR <= 1'b0;
            SLEEP_REQUEST <= 1'b0;
        end else begin
            program_counter <= next_pc;
            ir <= next_ir;
            WORKING_ACCUMULATOR <= next_w;
            STATUS_FLAGS <= next_status;
            indirect_pointer <= next_ptr;
            TIMER_COUNT_VALUE <= next_tmr;
            IO_BANK_A_LATCH <= next_lat_a;
            IO_BANK_B_LATCH <= next_lat_b;
            IO_BANK_C_LATCH <= next_lat_c;
            PRESCALER_TIMER_CONFIG <= next_opt;
            PIN_DIRECTION_A <= next_dir_a;
            PIN_DIRECTION_B <= next_dir_b;
            PIN_DIRECTION_C <= next_dir_c;
            // Address of the next operand uses the pointer as this cycle leaves it
            DATA_ADDR <= eff_addr(next_ir, ptr_view(next_ptr));
            DATA_WADDR <= DATA_ADDR;
            DATA_WDATA <= res;
            DATA_WE <= next_we;
            WATCHDOG_CLEAR <= do_clrwdt;
            SLEEP_REQUEST <= do_sleep;
        end
    end
endmodule

// File: verification/cfr_core_asserts.sv
`timescale 1ns/1ns

// ****
// Core port checks
// ****
module cfr_core_asserts #(
    parameter PC_WIDTH = 11,
    parameter HAS_PORT_C = 1
) (
    // Clock and resets
    input wire CLK,
    input wire RST_B,
    input wire EXTERNAL_CLEAR_INPUT_B,
    input wire WATCHDOG_RESET,
    // Observed
    input wire [PC_WIDTH-1:0] PROG_ADDR,
    input wire [11:0] PROG_DATA,
    input wire [6:0] DATA_WADDR,
    input wire DATA_WE,
    input wire [7:0] PIN_DIRECTION_B,
    input wire [7:0] WORKING_ACCUMULATOR,
    input wire [7:0] STATUS_FLAGS,
    input wire [5:0] PRESCALER_TIMER_CONFIG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    chk_reset_vector: assert property ($rose(RST_B) |-> PROG_ADDR == '1)
        else $error("bad vector");
    chk_vector_wrap: assert property (
        $rose(RST_B) && PROG_DATA == 12'h000 |=> PROG_ADDR == '0)
        else $error("no wrap");
    // Warm reset terms keep the step check off while the clear sync is busy
    chk_addr_step: assert property (
        (EXTERNAL_CLEAR_INPUT_B && !WATCHDOG_RESET) [*2] ##0 PROG_DATA == 12'h000
        ##1 !WATCHDOG_RESET |=> PROG_ADDR == $past(PROG_ADDR) + 1'b1)
        else $error("bad step");
    chk_warm_state: assert property (
        WATCHDOG_RESET |=> PROG_ADDR == '1 && PIN_DIRECTION_B == 8'hff
        && PRESCALER_TIMER_CONFIG == 6'h3f && STATUS_FLAGS[7:4] == 4'h0)
        else $error("bad warm state");
    chk_warm_keeps: assert property (
        WATCHDOG_RESET |=> $stable(WORKING_ACCUMULATOR))
        else $error("accumulator lost");
    chk_clear_sync: assert property (
        !EXTERNAL_CLEAR_INPUT_B [*3] |=> PROG_ADDR == '1)
        else $error("clear ignored");
    chk_sfr_internal: assert property (
        DATA_WE |-> DATA_WADDR[4:0] > ((HAS_PORT_C != 0) ? 5'h07 : 5'h06))
        else $error("special register in file");
    chk_config_load: assert property (
        (EXTERNAL_CLEAR_INPUT_B && !WATCHDOG_RESET) [*2] ##0 PROG_DATA == 12'h000
        ##1 PROG_DATA == 12'h002 && !WATCHDOG_RESET ##1 !WATCHDOG_RESET
        |=> PRESCALER_TIMER_CONFIG == $past(WORKING_ACCUMULATOR[5:0]))
        else $error("config not loaded");
endmodule

bind cfr_core cfr_core_asserts #(.PC_WIDTH(PC_WIDTH), .HAS_PORT_C(HAS_PORT_C)) u_chk (
    .CLK(CLK), .RST_B(RST_B), .EXTERNAL_CLEAR_INPUT_B(EXTERNAL_CLEAR_INPUT_B),
    .WATCHDOG_RESET(WATCHDOG_RESET), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
    .DATA_WADDR(DATA_WADDR), .DATA_WE(DATA_WE), .PIN_DIRECTION_B(PIN_DIRECTION_B),
    .WORKING_ACCUMULATOR(WORKING_ACCUMULATOR), .STATUS_FLAGS(STATUS_FLAGS),
    .PRESCALER_TIMER_CONFIG(PRESCALER_TIMER_CONFIG)
);

// File: verification/cfr_mem.sv
`timescale 1ns/1ns

// ****
// Program store and file
// ****
module cfr_mem (
    // Program bus
    input wire logic [10:0] prog_addr,
    output wire logic [11:0] prog_data,
    // Data file
    input wire logic clk,
    input wire logic [6:0] data_addr,
    output wire logic [7:0] data_rdata,
    input wire logic [6:0] data_waddr,
    input wire logic [7:0] data_wdata,
    input wire logic data_we
);
    logic [11:0] rom [0:2047];
    // File starts unknown, as a real array does
    logic [7:0] ram [0:127];

    assign prog_data = rom[prog_addr];
    assign data_rdata = ram[data_addr];
    always @(posedge clk) begin
        if (data_we) begin
            ram[data_waddr] <= data_wdata;
        end
    end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ns

// ****
// Core testbench
// ****
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ext_b = 1'b1;
    logic wdt = 1'b0;
    wire [10:0] pa;
    wire [11:0] pd;
    wire [6:0] da, dwa;
    wire [7:0] drd, dwd, acc, st, dir_b;
    wire [5:0] cfg;
    wire dwe;
    integer seed = 9633;
    integer mismatches = 0;
    integer check_count = 0;
    integer i;
    integer n;
    logic [7:0] a;
    logic [7:0] b;
    logic [10:0] exp_r [0:11];

    always #20 clk = ~clk;

    cfr_core u_cfr_core (
        .CLK(clk), .RST_B(rst_b), .EXTERNAL_CLEAR_INPUT_B(ext_b), .WATCHDOG_RESET(wdt),
        .PROG_ADDR(pa), .PROG_DATA(pd), .DATA_ADDR(da), .DATA_RDATA(drd),
        .DATA_WADDR(dwa), .DATA_WDATA(dwd), .DATA_WE(dwe), .IO_BANK_A_LATCH(),
        .IO_BANK_B_LATCH(), .IO_BANK_C_LATCH(), .PIN_DIRECTION_A(), .PIN_DIRECTION_B(dir_b),
        .PIN_DIRECTION_C(), .WORKING_ACCUMULATOR(acc), .STATUS_FLAGS(st),
        .TIMER_COUNT_VALUE(), .PRESCALER_TIMER_CONFIG(cfg), .WATCHDOG_CLEAR(),
        .SLEEP_REQUEST()
    );
    cfr_mem u_cfr_mem (
        .clk(clk), .prog_addr(pa), .prog_data(pd), .data_addr(da), .data_rdata(drd),
        .data_waddr(dwa), .data_wdata(dwd), .data_we(dwe)
    );

    // Returns zero, half carry, carry and result; subtract is x minus w
    function automatic logic [10:0] ref_op(input logic sub, input logic [7:0] x,
        input logic [7:0] w);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, x} + {1'b0, sub ? ~w : w} + {8'h00, sub};
        h = {1'b0, x[3:0]} + {1'b0, sub ? ~w[3:0] : w[3:0]} + {4'h0, sub};
        return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    task check(input string name, input logic [10:0] exp, input logic [10:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task wait_addr(input logic [10:0] target);
        n = 0;
        while (pa !== target && n < 400) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        if (pa !== target) begin
            mismatches = mismatches + 1;
            stop_test;
        end
    endtask

    initial begin
        for (i = 0; i < 2048; i = i + 1) begin
            u_cfr_mem.rom[i] = 12'h000;
        end
        for (i = 0; i < 12; i = i + 1) begin
            a = (i == 0) ? 8'hff : (i == 1) ? 8'h10 : $random(seed);
            b = (i < 2) ? 8'h01 : $random(seed);
            if (i == 3) begin
                a = b;
            end
            exp_r[i] = ref_op(i[0], a, b);
            u_cfr_mem.rom[6 * i] = {4'hc, a};
            u_cfr_mem.rom[6 * i + 1] = {7'h01, 5'h08 + i[4:0]};
            u_cfr_mem.rom[6 * i + 2] = {4'hc, b};
            u_cfr_mem.rom[6 * i + 3] = {i[0] ? 6'h02 : 6'h07, 1'b1, 5'h08 + i[4:0]};
            u_cfr_mem.rom[6 * i + 4] = 12'h203;
            u_cfr_mem.rom[6 * i + 5] = {7'h01, 5'h14 + i[4:0]};
        end
        u_cfr_mem.rom[72] = 12'hc15;
        u_cfr_mem.rom[74] = 12'h002;
        // Pointer to bank one, store through it, banked direct store, then page one
        u_cfr_mem.rom[75] = 12'hc3a;
        u_cfr_mem.rom[76] = 12'h024;
        u_cfr_mem.rom[77] = 12'hc5c;
        u_cfr_mem.rom[78] = 12'h020;
        u_cfr_mem.rom[79] = 12'h204;
        u_cfr_mem.rom[80] = 12'h03f;
        u_cfr_mem.rom[81] = 12'h5a3;
        u_cfr_mem.rom[82] = 12'ha51;
        u_cfr_mem.rom[593] = 12'ha51;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        check("counter", 11'h7ff, pa);
        check("direction", 8'hff, dir_b);
        check("config", 6'h3f, cfg);
        check("flags", 5'h03, st[7:3]);
        $display("test reset done");
        wait_addr(11'h252);
        @(posedge clk);
        #1;
        check("branch", 11'h251, pa);
        @(posedge clk);
        #1;
        check("refetch", 11'h252, pa);
        for (i = 0; i < 12; i = i + 1) begin
            check("result", exp_r[i][7:0], u_cfr_mem.ram[8 + i]);
            check("flags", {5'h03, exp_r[i][10:8]}, u_cfr_mem.ram[20 + i]);
        end
        check("config", 6'h15, cfg);
        check("indirect", 8'h5c, u_cfr_mem.ram[7'h3a]);
        check("bank", 8'hba, u_cfr_mem.ram[7'h3f]);
        $display("test arithmetic done");
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        #1;
        check("counter", 11'h7ff, pa);
        check("cause", 2'b01, st[4:3]);
        check("accumulator", 8'hba, acc);
        check("config", 6'h3f, cfg);
        $display("test watchdog done");
        @(posedge clk);
        ext_b <= 1'b0;
        repeat (4) @(posedge clk);
        ext_b <= 1'b1;
        #1;
        check("counter", 11'h7ff, pa);
        check("cause", 2'b01, st[4:3]);
        $display("test clear done");
        stop_test;
    end
endmodule
